/* inc/bip_pkg.sv */
// bip_pkg: register map, field layout, reset values and timing
// constants of the bulk-in pacing and event report block.
// assumes a 10 MHz core clock and a 32-bit register port.
package bip_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [11:0] BIP_OFF_BURST_LIMIT = 12'h090;
    localparam logic [11:0] BIP_OFF_SHORT_WAIT  = 12'h094;
    localparam logic [11:0] BIP_OFF_EVENT_CTL   = 12'h098;
    localparam logic [11:0] BIP_OFF_CONFIG      = 12'h0c0;
    localparam logic [11:0] BIP_OFF_IRQ_STATUS  = 12'h0c4;
    localparam logic [11:0] BIP_OFF_IRQ_MASK    = 12'h0c8;
    localparam logic [11:0] BIP_OFF_PENDING     = 12'h0cc;
    // ----------------------------------------
    // fields and reset values
    // ----------------------------------------
    localparam int          BIP_ALWAYS_BIT     = 31;
    localparam int          BIP_USB_STS_BIT    = 20;
    localparam logic [31:0] BIP_EVENT_MASK     = 32'h97ff_ffff;
    localparam logic [31:0] BIP_EVENT_SRC_MASK = 32'h17ff_ffff;
    localparam int          BIP_CFG_BURST_EN   = 0;
    localparam int          BIP_IRQ_ZLP        = 0;
    localparam int          BIP_IRQ_SHORT      = 1;
    localparam int          BIP_IRQ_REPORT     = 2;
    localparam logic [7:0]  BIP_RST_LIMIT      = 8'h00;
    localparam logic [15:0] BIP_RST_WAIT       = 16'h0800;
    localparam logic [31:0] BIP_RST_EVENT_CTL  = 32'h0000_0000;
    // ----------------------------------------
    // sizes and timing
    // ----------------------------------------
    localparam logic [17:0] BIP_LIMIT_MIN_BYTES = 18'd2048;
    localparam logic [9:0]  BIP_HS_UNIT_BYTES   = 10'd512;
    localparam logic [9:0]  BIP_FS_UNIT_BYTES   = 10'd64;
    localparam int          BIP_WAIT_UNIT_PS    = 16667;
    localparam int          BIP_CLK_PERIOD_PS   = 100000;
    // pacing states
    typedef enum logic [1:0]
    {
        BIP_ST_IDLE = 2'b01,
        BIP_ST_WAIT = 2'b10
    } bip_state_t;
endpackage : bip_pkg

/* src/bip_core.sv */
// bip_core: bulk-in pacing (burst limit, short packet wait) and the
// event enables that trigger interrupt endpoint status reports.
// assumes one 10 MHz clock, synchronous inputs and a source that
// holds its packet request until granted.
//
// Contract
// - after the burst limit of contiguous data, end the burst with a zero-length packet
// - limit field counts 512 bytes at high speed, 64 bytes at full speed
// - the limit acts only while its configuration enable is set
// - a limit of 2048 bytes or less disables burst limiting
// - wait the programmed delay before every short or zero-length packet
// - delay counts 16.667 ns units and resets to 0800h
// - always-on bit sends a report every interval, else only on events
// - each event enable blocks at zero, allows at one, resets to zero
// - bit 28 enables reports on memory write done
// - bits 26..24 enable the idle entry, idle exit and receive idle events
// - bits 23..21 enable reset timeout, receive overflow and transmit error
// - bits 20..18 enable status change, transmitter off and receiver off
// - bits 17..15 enable phy, data port and mac error events
// - bits 14..12 enable tx underrun, tx overrun and frame pending
// - bits 11..0 enable the general-purpose pin events, one per pin
// - status change flags are combined into the status change event
`timescale 1ns/1ps
`default_nettype none
module bip_core
    import bip_pkg::*;
(
    // clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        RST_N_I,
    // register port
    input  wire logic [11:0] ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    // bulk-in packet stream
    input  wire logic        HIGH_SPEED_I,
    input  wire logic        PKT_REQ_I,
    input  wire logic [9:0]  PKT_LEN_I,
    output logic             PKT_GO_O,
    output logic             ZLP_GO_O,
    // event report
    input  wire logic [31:0] EVENT_I,
    input  wire logic [15:0] USB_STS_I,
    input  wire logic        POLL_I,
    output logic             REPORT_O,
    output logic      [31:0] REPORT_DATA_O,
    // interrupt
    output logic             IRQ_O
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // limit in bytes for the current bus speed
    function automatic logic [17:0] cap_bytes(input logic [7:0] lim,
                                              input logic       hs);
        logic [17:0] unit;
        unit = hs ? {8'h00, BIP_HS_UNIT_BYTES} : {8'h00, BIP_FS_UNIT_BYTES};
        return 18'(unit * {10'h000, lim});
    endfunction : cap_bytes

    // delay units to clock cycles, rounded up, never below one
    function automatic logic [13:0] wait_cycles(input logic [15:0] d);
        int c;
        c = (int'(d) * BIP_WAIT_UNIT_PS + BIP_CLK_PERIOD_PS - 1)
            / BIP_CLK_PERIOD_PS;
        if (c < 1)
        begin
            c = 1;
        end
        return 14'(c);
    endfunction : wait_cycles

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        bip_state_t  st;
        logic [7:0]  limit;
        logic [15:0] dly;
        logic [31:0] ectl;
        logic        burst_en;
        logic [2:0]  ists;
        logic [2:0]  imsk;
        logic [31:0] rdata;
        logic [17:0] bcnt;
        logic [13:0] wcnt;
        logic        zlp;
        logic        pkt_go;
        logic        zlp_go;
        logic [31:0] pend;
        logic        rep;
        logic [31:0] rep_data;
    } bip_regs_t;

    bip_regs_t   r;
    bip_regs_t   n;
    logic [17:0] cap;
    logic        cap_on;
    logic [9:0]  max_pkt;
    logic [31:0] src;
    logic        wr_hit_ists;

    // burst limit acts only when enabled and above the floor
    assign cap     = cap_bytes(r.limit, HIGH_SPEED_I);
    assign cap_on  = r.burst_en && (cap > BIP_LIMIT_MIN_BYTES);
    assign max_pkt = HIGH_SPEED_I ? BIP_HS_UNIT_BYTES : BIP_FS_UNIT_BYTES;
    // status change flags fold into one event bit
    always_comb
    begin
        src = EVENT_I & BIP_EVENT_SRC_MASK;
        src[BIP_USB_STS_BIT] = |USB_STS_I;
    end
    assign wr_hit_ists = WR_I && (ADDR_I == BIP_OFF_IRQ_STATUS);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        n = r;
        n.pkt_go = 1'b0;
        n.zlp_go = 1'b0;
        n.rep    = 1'b0;
        n.rdata  = 32'h0000_0000;
        // register writes
        if (WR_I)
        begin
            unique case (ADDR_I)
                BIP_OFF_BURST_LIMIT: n.limit    = WDATA_I[7:0];
                BIP_OFF_SHORT_WAIT:  n.dly      = WDATA_I[15:0];
                BIP_OFF_EVENT_CTL:   n.ectl     = WDATA_I & BIP_EVENT_MASK;
                BIP_OFF_CONFIG:      n.burst_en = WDATA_I[BIP_CFG_BURST_EN];
                BIP_OFF_IRQ_MASK:    n.imsk     = WDATA_I[2:0];
                default:             n.limit    = r.limit;
            endcase
        end
        // register reads, data in the following cycle; unmapped reads zero
        if (RD_I)
        begin
            unique case (ADDR_I)
                BIP_OFF_BURST_LIMIT: n.rdata = {24'h000000, r.limit};
                BIP_OFF_SHORT_WAIT:  n.rdata = {16'h0000, r.dly};
                BIP_OFF_EVENT_CTL:   n.rdata = r.ectl;
                BIP_OFF_CONFIG:      n.rdata = {31'h0, r.burst_en};
                BIP_OFF_IRQ_STATUS:  n.rdata = {29'h0, r.ists};
                BIP_OFF_IRQ_MASK:    n.rdata = {29'h0, r.imsk};
                BIP_OFF_PENDING:     n.rdata = r.pend;
                default:             n.rdata = 32'h0000_0000;
            endcase
        end
        // status clears by writing one
        if (wr_hit_ists)
        begin
            n.ists = r.ists & ~WDATA_I[2:0];
        end
        // pacing of the bulk-in transmitter
        unique case (r.st)
            BIP_ST_IDLE:
            begin
                if (cap_on && (r.bcnt >= cap))
                begin
                    // burst used up: a zero-length packet closes it
                    n.zlp  = 1'b1;
                    n.wcnt = wait_cycles(r.dly);
                    n.st   = BIP_ST_WAIT;
                end
                // a request still seen in the cycle of its own grant is the same
                // packet: the source only drops it at the edge after the pulse
                else if (PKT_REQ_I && !r.pkt_go && (PKT_LEN_I >= max_pkt))
                begin
                    n.pkt_go = 1'b1;
                    n.bcnt   = r.bcnt + {8'h00, PKT_LEN_I};
                end
                else if (PKT_REQ_I && !r.pkt_go)
                begin
                    // short packet, wait before it goes out
                    n.zlp  = 1'b0;
                    n.wcnt = wait_cycles(r.dly);
                    n.st   = BIP_ST_WAIT;
                end
            end
            BIP_ST_WAIT:
            begin
                if (r.wcnt <= 14'd1)
                begin
                    // either kind of short packet ends the burst
                    n.pkt_go = ~r.zlp;
                    n.zlp_go = r.zlp;
                    n.bcnt   = 18'h00000;
                    n.st     = BIP_ST_IDLE;
                    // built on the cleared value so a write of one to the other
                    // bit is not undone; the set still wins over its own clear
                    n.ists[BIP_IRQ_ZLP]   = n.ists[BIP_IRQ_ZLP] | r.zlp;
                    n.ists[BIP_IRQ_SHORT] = n.ists[BIP_IRQ_SHORT] | ~r.zlp;
                end
                else
                begin
                    n.wcnt = r.wcnt - 14'd1;
                end
            end
            default:
            begin
                n.st = BIP_ST_IDLE;
            end
        endcase
        // interrupt endpoint report; a report takes what is pending now
        if (POLL_I && ((r.pend != 32'h0) || r.ectl[BIP_ALWAYS_BIT]))
        begin
            n.rep      = 1'b1;
            n.rep_data = r.pend;
            n.pend     = 32'h0000_0000;
            n.ists[BIP_IRQ_REPORT] = 1'b1;
        end
        // enabled events latch; a new event wins over the report clear
        n.pend = n.pend | (src & r.ectl);
        if (!RST_N_I)
        begin
            n.st       = BIP_ST_IDLE;
            n.limit    = BIP_RST_LIMIT;
            n.dly      = BIP_RST_WAIT;
            n.ectl     = BIP_RST_EVENT_CTL;
            n.burst_en = 1'b0;
            n.ists     = 3'h0;
            n.imsk     = 3'h0;
            n.rdata    = 32'h0000_0000;
            n.bcnt     = 18'h00000;
            n.wcnt     = 14'h0000;
            n.zlp      = 1'b0;
            n.pkt_go   = 1'b0;
            n.zlp_go   = 1'b0;
            n.pend     = 32'h0000_0000;
            n.rep      = 1'b0;
            n.rep_data = 32'h0000_0000;
        end
    end

    // register the whole state, reset is folded into the next value
    always_ff @(posedge CLOCK_I)
    begin
        r <= n;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign RDATA_O       = r.rdata;
    assign PKT_GO_O      = r.pkt_go;
    assign ZLP_GO_O      = r.zlp_go;
    assign REPORT_O      = r.rep;
    assign REPORT_DATA_O = r.rep_data;
    assign IRQ_O         = |(r.ists & r.imsk);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);

    burst_zlp_a: assert property ((r.st == BIP_ST_IDLE) && cap_on && (r.bcnt >= cap)
        |=> (r.st == BIP_ST_WAIT) && r.zlp)
        else $error("exhausted burst did not start a zero-length wait");
    limit_unit_a: assert property (cap == (HIGH_SPEED_I ? {r.limit, 9'h000}
        : {3'h0, r.limit, 6'h00}))
        else $error("burst limit unit wrong for bus speed");
    cap_enable_a: assert property (!r.burst_en |-> !cap_on)
        else $error("burst limit active while disabled");
    cap_floor_a: assert property ((cap <= 18'd2048) |-> !cap_on)
        else $error("burst limit active at or below 2048 bytes");
    short_wait_a: assert property ((r.pkt_go || r.zlp_go) && $past(r.st == BIP_ST_WAIT)
        |-> $past(r.wcnt) <= 14'd1)
        else $error("short packet released before its wait ended");
    wait_load_a: assert property ($rose(r.st == BIP_ST_WAIT)
        |-> r.wcnt == wait_cycles($past(r.dly)))
        else $error("wait count not derived from delay field");
    wait_reset_a: assert property ($past(!RST_N_I) |-> (r.dly == 16'h0800)
        && (r.ectl == 32'h0))
        else $error("delay or enables wrong after reset");
    always_on_a: assert property (POLL_I && r.ectl[31] |=> r.rep)
        else $error("always-on poll sent no report");
    quiet_poll_a: assert property (POLL_I && !r.ectl[31] && (r.pend == 32'h0)
        |=> !r.rep)
        else $error("report sent with nothing pending");
    // a report carries what was pending at its poll
    report_data_a: assert property (r.rep |-> r.rep_data == $past(r.pend))
        else $error("report data differ from pending events");
    // reports only answer a poll
    report_poll_a: assert property (r.rep |-> $past(POLL_I))
        else $error("report sent without a poll");
    // report data hold between reports
    report_hold_a: assert property (!r.rep |-> $stable(r.rep_data))
        else $error("report data changed without a report");
    // reserved enable bits never store
    enable_mask_a: assert property ((r.ectl & ~BIP_EVENT_MASK) == 32'h0)
        else $error("reserved event enable bit set");
    event_gate_a: assert property (((r.pend & ~$past(r.pend)) & ~$past(r.ectl))
        == 32'h0)
        else $error("disabled event became pending");
    event_latch_a: assert property (|(EVENT_I & r.ectl & 32'h17ef_ffff)
        |=> |r.pend)
        else $error("enabled event not latched");
    status_fold_a: assert property (r.ectl[20] && (USB_STS_I != 16'h0)
        |=> r.pend[20])
        else $error("status change flags not reported");
    pend_hold_a: assert property (!POLL_I |=> ((r.pend & $past(r.pend))
        == $past(r.pend)))
        else $error("pending event lost without a report");


    // ----------------------------------------
    // bus, grant and status checks
    // ----------------------------------------
    // read data stand one cycle only, zero otherwise
    rdata_idle_a: assert property (!$past(RD_I) |-> (RDATA_O == 32'h0))
        else $error("read data present without a read");
    // delay field takes the written value
    delay_write_a: assert property (WR_I && (ADDR_I == BIP_OFF_SHORT_WAIT)
        |=> r.dly == $past(WDATA_I[15:0]))
        else $error("delay field write lost");
    // one kind of packet at a time
    grant_excl_a: assert property (!(r.pkt_go && r.zlp_go))
        else $error("packet and zero-length grant together");
    // a held request is granted once, not again in its grant cycle
    grant_single_a: assert property (r.pkt_go |=> !r.pkt_go)
        else $error("one request granted twice");
    // a full packet in idle goes out at the next edge
    full_grant_a: assert property ((r.st == BIP_ST_IDLE) && !r.pkt_go
        && !(cap_on && (r.bcnt >= cap)) && PKT_REQ_I && (PKT_LEN_I >= max_pkt)
        |=> r.pkt_go)
        else $error("full packet not granted");
    // a zero-length packet restarts the burst count
    zlp_clear_a: assert property (r.zlp_go |-> (r.bcnt == 18'h00000))
        else $error("burst count kept after zero-length packet");
    // a zero-length wait starts only with the limit active
    zlp_cap_a: assert property ($rose(r.st == BIP_ST_WAIT) && r.zlp
        |-> $past(cap_on))
        else $error("zero-length packet without active limit");
    // the wait counter never sits at zero while waiting
    wait_nonzero_a: assert property ((r.st == BIP_ST_WAIT) |-> (r.wcnt != 14'h0))
        else $error("wait counter empty in wait state");
    // the event of a finished wait sets its status bit, set beats clear
    status_set_a: assert property ((r.st == BIP_ST_WAIT) && (r.wcnt <= 14'd1)
        |=> (r.zlp_go ? r.ists[BIP_IRQ_ZLP] : r.ists[BIP_IRQ_SHORT]))
        else $error("finished wait did not set its status bit");
    // writing ones clears the status when nothing sets it
    status_clear_a: assert property (wr_hit_ists && (WDATA_I[2:0] == 3'h7)
        && (r.st == BIP_ST_IDLE) && !POLL_I |=> (r.ists == 3'h0))
        else $error("status bits not cleared by writing ones");

    // ----------------------------------------
    // main scenarios
    // ----------------------------------------
    zlp_sent_c: cover property (r.zlp_go);
    burst_off_c: cover property (r.burst_en && !cap_on && r.pkt_go);
    short_sent_c: cover property (r.pkt_go && $past(r.st == BIP_ST_WAIT));
    report_sent_c: cover property (r.rep && (r.rep_data != 32'h0));
    irq_raised_c: cover property (IRQ_O);
endmodule : bip_core
`default_nettype wire

/* sim/bip_host_model.sv */
// bip_host_model: usb host side of the block; polls the status
// endpoint and counts the bulk-in packets handed to it.
// assumes the bench calls poll_once from its own thread.
`timescale 1ns/1ps
`default_nettype none
module bip_host_model
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // bulk-in and report stream
    input  wire logic        pkt_go_i,
    input  wire logic        zlp_go_i,
    input  wire logic        report_i,
    input  wire logic [31:0] report_data_i,
    // interval tick towards the device
    output logic             poll_o
);
    int          pkt_count = 0;
    int          zlp_count = 0;
    int          rep_count = 0;
    logic [31:0] last_data = 32'h0;
    initial poll_o = 1'b0;
    // counting waits for reset so pulses seen in reset are not taken
    always @(posedge clk_i)
    begin
        if (rst_n_i && pkt_go_i)
            pkt_count++;
        if (rst_n_i && zlp_go_i)
            zlp_count++;
        if (rst_n_i && report_i)
        begin
            rep_count++;
            last_data = report_data_i;
        end
    end
    // one interval tick after gap cycles; a large gap models a slow host
    task automatic poll_once(input int gap);
        repeat (gap) @(posedge clk_i);
        poll_o <= 1'b1;
        @(posedge clk_i);
        poll_o <= 1'b0;
    endtask : poll_once
endmodule : bip_host_model
`default_nettype wire

/* sim/tb_bip_core.sv */
// tb_bip_core: self-checking bench of the pacing and report block.
// assumes bip_host_model as far side and a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_bip_core;
    import bip_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        hs = 1'b1;
    logic        pkt_req = 1'b0;
    logic [9:0]  pkt_len = 10'h0;
    logic [31:0] event_in = 32'h0;
    logic [15:0] usb_sts = 16'h0;
    logic [31:0] rdata;
    logic [31:0] report_data;
    logic        pkt_go;
    logic        zlp_go;
    logic        poll;
    logic        report;
    logic        irq;
    logic [31:0] rv;
    int          failures = 0;
    int          cmp_count = 0;
    int          n;
    always #50 clk = ~clk;
    bip_core uut (.CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .HIGH_SPEED_I(hs), .PKT_REQ_I(pkt_req),
        .PKT_LEN_I(pkt_len), .PKT_GO_O(pkt_go), .ZLP_GO_O(zlp_go), .EVENT_I(event_in),
        .USB_STS_I(usb_sts), .POLL_I(poll), .REPORT_O(report),
        .REPORT_DATA_O(report_data), .IRQ_O(irq));
    bip_host_model host (.clk_i(clk), .rst_n_i(rst_n), .pkt_go_i(pkt_go),
        .zlp_go_i(zlp_go), .report_i(report), .report_data_i(report_data),
        .poll_o(poll));
    // ----------------------------------------
    // shared bus and compare tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    // request held until granted, dropped at the next edge
    task automatic send_pkt(input logic [9:0] len, output int cyc);
        @(posedge clk);
        pkt_req <= 1'b1;
        pkt_len <= len;
        cyc = 0;
        do
        begin
            @(posedge clk);
            #1 cyc++;
        end while (pkt_go !== 1'b1 && cyc < 200);
        @(posedge clk);
        pkt_req <= 1'b0;
    endtask : send_pkt
    // wait in 10 MHz cycles: 16.667 ns units rounded up, at least one
    function automatic int wcyc(input int w);
        int c;
        c = (w * 16667 + 99999) / 100000;
        return (c < 1) ? 1 : c;
    endfunction : wcyc
    task automatic test_done();
        if (failures == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd_reg(BIP_OFF_BURST_LIMIT, rv);
        chk("limit reset", rv, 32'h0);
        rd_reg(BIP_OFF_SHORT_WAIT, rv);
        chk("wait reset", rv, 32'h0000_0800);
        rd_reg(BIP_OFF_EVENT_CTL, rv);
        chk("event ctl reset", rv, 32'h0);
        rd_reg(12'h0fc, rv);
        chk("unmapped read", rv, 32'h0);
        wr_reg(BIP_OFF_EVENT_CTL, 32'hffff_ffff);
        rd_reg(BIP_OFF_EVENT_CTL, rv);
        chk("event ctl bits", rv, 32'h97ff_ffff);
        wr_reg(BIP_OFF_SHORT_WAIT, 32'hffff_ffff);
        rd_reg(BIP_OFF_SHORT_WAIT, rv);
        chk("wait field", rv, 32'h0000_ffff);
    endtask : t_regs
    task automatic t_wait(input int w, input logic [9:0] len, input int exp);
        wr_reg(BIP_OFF_SHORT_WAIT, w);
        send_pkt(len, n);
        chk("grant delay", n, exp);
    endtask : t_wait
    // a short packet first clears any byte count left over
    task automatic t_burst(input logic s, input logic [9:0] len, input logic [7:0] lim,
                           input logic cfg, input int npk, input int exp_zlp);
        int z;
        hs <= s;
        wr_reg(BIP_OFF_BURST_LIMIT, {24'h0, lim});
        wr_reg(BIP_OFF_CONFIG, {31'h0, cfg});
        send_pkt(10'd1, n);
        repeat (10) @(posedge clk);
        z = host.zlp_count;
        repeat (npk) send_pkt(len, n);
        repeat (10) @(posedge clk);
        chk("zlp count", 32'(host.zlp_count - z), 32'(exp_zlp));
    endtask : t_burst
    // every event enabled alone while all sources fire at once
    task automatic t_events();
        for (int i = 0; i < 29; i++)
        begin
            if (BIP_EVENT_SRC_MASK[i])
            begin
                wr_reg(BIP_OFF_EVENT_CTL, 32'h1 << i);
                @(posedge clk);
                event_in <= 32'hffff_ffff;
                usb_sts <= 16'h0010;
                @(posedge clk);
                event_in <= 32'h0;
                usb_sts <= 16'h0;
                host.poll_once(6);
                repeat (2) @(posedge clk);
                chk("report data", host.last_data, 32'h1 << i);
            end
        end
        n = host.rep_count;
        wr_reg(BIP_OFF_EVENT_CTL, 32'h0);
        host.poll_once(1);
        repeat (2) @(posedge clk);
        chk("quiet poll", 32'(host.rep_count), 32'(n));
        wr_reg(BIP_OFF_EVENT_CTL, 32'h8000_0000);
        host.poll_once(1);
        repeat (2) @(posedge clk);
        chk("always report", 32'(host.rep_count), 32'(n + 1));
        chk("always data", host.last_data, 32'h0);
    endtask : t_events
    task automatic t_irq();
        chk("irq masked", {31'h0, irq}, 32'h0);
        rd_reg(BIP_OFF_IRQ_STATUS, rv);
        chk("irq status", rv, 32'h7);
        wr_reg(BIP_OFF_IRQ_MASK, 32'h4);
        repeat (2) @(posedge clk);
        chk("irq raised", {31'h0, irq}, 32'h1);
        wr_reg(BIP_OFF_IRQ_STATUS, 32'h7);
        repeat (2) @(posedge clk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
    endtask : t_irq
    // main sequence: reset two cycles, then each scenario in turn
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_wait(6, 10'd10, 1 + wcyc(6));
        t_wait(6, 10'd0, 1 + wcyc(6));
        t_wait(6, 10'd512, 1);
        t_wait(60, 10'd5, 1 + wcyc(60));
        t_wait(6, 10'd5, 1 + wcyc(6));
        t_burst(1'b1, 10'd512, 8'd5, 1'b1, 5, 1);
        t_burst(1'b1, 10'd512, 8'd5, 1'b1, 4, 0);
        t_burst(1'b1, 10'd512, 8'd4, 1'b1, 5, 0);
        t_burst(1'b1, 10'd512, 8'd5, 1'b0, 5, 0);
        t_burst(1'b0, 10'd64, 8'd33, 1'b1, 33, 1);
        t_burst(1'b0, 10'd64, 8'd32, 1'b1, 33, 0);
        t_events();
        t_irq();
        test_done();
    end
    // watchdog: the full run needs a few thousand cycles at most
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done();
    end
endmodule : tb_bip_core
`default_nettype wire
